// file: self_program_flash_control.sv
// Chosen here: the Avalon-MM interface to the registers.
`include "spm_cfg.svh"
module self_program_flash_control
	import spm_pkg::*;
#(
	parameter bit RWW_SUPPORT = 1'b1,
	parameter int OP_US       = `OP_US
) (
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RSTN,
	// Avalon-MM slave
	input  wire logic [7:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	input  wire logic [3:0]  I_AVS_BYTEENABLE,
	output logic      [31:0] O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	// CPU core
	input  wire logic        I_SPM,
	input  wire logic        I_LPM,
	input  wire logic [15:0] I_ZPTR,
	input  wire logic [15:0] I_R1R0,
	input  wire logic [12:0] I_CPU_PC,
	input  wire logic        I_GLOBAL_IE,
	input  wire logic        I_EE_BUSY,
	output logic             O_CPU_STALL,
	output logic             O_IRQ,
	output logic             O_LPM_VALID,
	output logic      [7:0]  O_LPM_DATA,
	// Fuse pins, static straps
	input  wire logic [1:0]  I_BOOT_SIZE,
	input  wire logic [7:0]  I_LOCK_BITS,
	input  wire logic [7:0]  I_FUSE_LO,
	input  wire logic [7:0]  I_FUSE_HI,
	input  wire logic [7:0]  I_FUSE_EXT,
	// Flash array
	input  wire logic [4:0]  I_FLASH_BUF_IDX,
	output logic      [15:0] O_FLASH_BUF_DATA,
	output logic             O_FLASH_ERASE,
	output logic             O_FLASH_WRITE,
	output logic      [7:0]  O_FLASH_PAGE
);
	logic [1:0]  rst_sync_ff;
	logic        rst_n;
	logic [33:0] pin_s1_ff;
	logic [33:0] pin_s2_ff;
	logic [1:0]  boot_size;
	logic [7:0]  lock_bits;
	logic [7:0]  fuse_lo;
	logic [7:0]  fuse_hi;
	logic [7:0]  fuse_ext;
	logic        irq_en_ff;
	logic        rww_busy_ff;
	logic        rww_re_ff;
	logic        lock_sel_ff;
	logic        pg_write_ff;
	logic        pg_erase_ff;
	logic        self_en_ff;
	logic [2:0]  arm_ff;
	logic [2:0]  load_ff;
	op_state_t   state_ff;
	op_desc_t    op_ff;
	op_desc_t    nxt_op;
	logic        wait_ff;
	logic        hit;
	logic        wr_commit;
	logic [4:0]  wr_pat;
	logic        wr_legal;
	logic [7:0]  csr_val;
	logic        spm_ok;
	logic        in_boot;
	logic        lpm_fuse;
	logic        op_start;
	logic        op_done;
	logic        buf_wr;
	logic        buf_clear;
	logic        filling;
	logic [15:0] buf_rd;

	function automatic logic [12:0] boot_start(input logic [1:0] sz);
		if (sz == 2'b00)
			boot_start = `BOOT_START_0;
		else if (sz == 2'b01)
			boot_start = `BOOT_START_1;
		else if (sz == 2'b10)
			boot_start = `BOOT_START_2;
		else
			boot_start = `BOOT_START_3;
	endfunction

	function automatic logic is_no_read_while_write_section(input logic [12:0] wa);
		is_no_read_while_write_section = (wa >= `NO_READ_WHILE_WRITE_SECTION_START);
	endfunction

	// Reset release through two flops
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN)
			rst_sync_ff <= 2'b00;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	// Fuse pins come from outside the clock domain
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= {34{1'b1}};
			pin_s2_ff <= {34{1'b1}};
		end else begin
			pin_s1_ff <= {I_BOOT_SIZE, I_LOCK_BITS, I_FUSE_LO, I_FUSE_HI, I_FUSE_EXT};
			pin_s2_ff <= pin_s1_ff;
		end
	end
	assign {boot_size, lock_bits, fuse_lo, fuse_hi, fuse_ext} = pin_s2_ff;

	// Bus decode
	assign hit       = (I_AVS_ADDRESS == `CSR_BYTE_ADDR);
	assign wr_commit = I_AVS_WRITE && !wait_ff && hit && I_AVS_BYTEENABLE[0];
	assign wr_pat    = I_AVS_WRITEDATA[4:0];
	// A new command is refused while one is armed or running
	assign wr_legal  = !self_en_ff && !I_EE_BUSY &&
		((wr_pat == `PAT_RWW_RE) || (wr_pat == `PAT_LOCK_SEL) ||
		 (wr_pat == `PAT_PG_WRITE) || (wr_pat == `PAT_PG_ERASE) ||
		 (wr_pat == `PAT_FILL));

	always_comb begin
		csr_val                = `CSR_RESET;
		csr_val[`BIT_IRQ_EN]   = irq_en_ff;
		csr_val[`BIT_RWW_BUSY] = RWW_SUPPORT && rww_busy_ff;
		csr_val[`BIT_RESERVED] = 1'b0;
		csr_val[`BIT_RWW_RE]   = rww_re_ff;
		csr_val[`BIT_LOCK_SEL] = lock_sel_ff;
		csr_val[`BIT_PG_WRITE] = pg_write_ff;
		csr_val[`BIT_PG_ERASE] = pg_erase_ff;
		csr_val[`BIT_SELF_EN]  = self_en_ff;
	end

	// One wait cycle, then the answer; writes land at that edge
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			wait_ff        <= 1'b1;
			O_AVS_READDATA <= 32'h0000_0000;
		end else if ((I_AVS_READ || I_AVS_WRITE) && wait_ff) begin
			wait_ff        <= 1'b0;
			O_AVS_READDATA <= hit ? {24'h00_0000, csr_val} : 32'h0000_0000;
		end else
			wait_ff <= 1'b1;
	end
	assign O_AVS_WAITREQUEST = wait_ff;

	// Store is honoured only from the boot section, which starts
	// at or above 13'h1C00 and so sits inside the NO_READ_WHILE_WRITE_SECTION part
	assign in_boot  = (I_CPU_PC >= boot_start(boot_size));
	assign spm_ok   = I_SPM && self_en_ff && (arm_ff != 3'h0) &&
		(state_ff == ST_IDLE) && in_boot && !I_EE_BUSY;
	assign lpm_fuse = I_LPM && lock_sel_ff && self_en_ff &&
		(load_ff != 3'h0) && !I_EE_BUSY;
	assign op_start = spm_ok && (pg_write_ff || pg_erase_ff);
	assign buf_wr   = spm_ok && !pg_write_ff && !pg_erase_ff &&
		!lock_sel_ff && !rww_re_ff;
	assign buf_clear = wr_commit && wr_legal && (wr_pat == `PAT_RWW_RE) && filling;

	always_comb begin
		nxt_op.page = I_ZPTR[13:6];
		nxt_op.read_while_write_section  = RWW_SUPPORT && !is_no_read_while_write_section(I_ZPTR[13:1]);
		nxt_op.stall = !nxt_op.read_while_write_section;
	end

	// Interrupt enable is plain storage, written on every committed register write
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n)
			irq_en_ff <= 1'b0;
		else if (wr_commit)
			irq_en_ff <= I_AVS_WRITEDATA[`BIT_IRQ_EN];
	end

	// Command bits and the arming windows
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			self_en_ff  <= 1'b0;
			rww_re_ff   <= 1'b0;
			lock_sel_ff <= 1'b0;
			pg_write_ff <= 1'b0;
			pg_erase_ff <= 1'b0;
			arm_ff      <= '0;
			load_ff     <= '0;
		end else if (wr_commit && wr_legal) begin
			self_en_ff  <= 1'b1;
			rww_re_ff   <= wr_pat[`BIT_RWW_RE];
			lock_sel_ff <= wr_pat[`BIT_LOCK_SEL];
			pg_write_ff <= wr_pat[`BIT_PG_WRITE];
			pg_erase_ff <= wr_pat[`BIT_PG_ERASE];
			arm_ff      <= `ARM_CYCLES;
			load_ff     <= `LOAD_CYCLES;
		end else if (state_ff != ST_IDLE) begin
			if (op_done) begin
				self_en_ff  <= 1'b0;
				pg_write_ff <= 1'b0;
				pg_erase_ff <= 1'b0;
			end
		end else if (op_start) begin
			arm_ff  <= '0;
			load_ff <= '0;
		end else if (spm_ok || lpm_fuse || (arm_ff == 3'h1)) begin
			self_en_ff  <= 1'b0;
			rww_re_ff   <= 1'b0;
			lock_sel_ff <= 1'b0;
			pg_write_ff <= 1'b0;
			pg_erase_ff <= 1'b0;
			arm_ff      <= '0;
			load_ff     <= '0;
		end else begin
			if (arm_ff != 3'h0)
				arm_ff <= arm_ff - 3'h1;
			if (load_ff != 3'h0)
				load_ff <= load_ff - 3'h1;
		end
	end

	// Erase and write sequencing
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			op_ff    <= '0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (op_start) begin
						op_ff    <= nxt_op;
						state_ff <= pg_erase_ff ? ST_ERASE : ST_WRITE;
					end
				end
				ST_ERASE, ST_WRITE: begin
					if (op_done)
						state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Flash-side outputs follow the running operation
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_FLASH_ERASE <= 1'b0;
			O_FLASH_WRITE <= 1'b0;
			O_FLASH_PAGE  <= '0;
			O_CPU_STALL   <= 1'b0;
		end else if (state_ff == ST_IDLE && op_start) begin
			O_FLASH_ERASE <= pg_erase_ff;
			O_FLASH_WRITE <= pg_write_ff;
			O_FLASH_PAGE  <= nxt_op.page;
			O_CPU_STALL   <= nxt_op.stall;
		end else if (op_done) begin
			O_FLASH_ERASE <= 1'b0;
			O_FLASH_WRITE <= 1'b0;
			O_CPU_STALL   <= 1'b0;
		end
	end

	// Busy stays after programming; only a re-enable store clears it
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n)
			rww_busy_ff <= 1'b0;
		else if (!RWW_SUPPORT)
			rww_busy_ff <= 1'b0;
		else if (op_start && nxt_op.read_while_write_section)
			rww_busy_ff <= 1'b1;
		else if (spm_ok && rww_re_ff)
			rww_busy_ff <= 1'b0;
	end

	// Fuse and lock readback; pins already read 0 when programmed
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_LPM_VALID <= 1'b0;
			O_LPM_DATA  <= 8'hFF;
		end else begin
			O_LPM_VALID <= lpm_fuse;
			if (lpm_fuse) begin
				if (I_ZPTR == `Z_LOCK)
					O_LPM_DATA <= lock_bits;
				else if (I_ZPTR == `Z_FUSE_LO)
					O_LPM_DATA <= fuse_lo;
				else if (I_ZPTR == `Z_FUSE_HI)
					O_LPM_DATA <= fuse_hi;
				else if (I_ZPTR == `Z_FUSE_EXT)
					O_LPM_DATA <= fuse_ext;
				else
					O_LPM_DATA <= I_ZPTR[0] ? lock_bits : fuse_lo;
			end
		end
	end

	// Ready interrupt: level while idle, masked during any write
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n)
			O_IRQ <= 1'b0;
		else
			O_IRQ <= irq_en_ff && I_GLOBAL_IE && !self_en_ff && !I_EE_BUSY;
	end

	page_buffer u_page_buffer (
		.i_clk     (I_CLK),
		.i_rst_n   (rst_n),
		.i_wr      (buf_wr),
		.i_wr_idx  (I_ZPTR[5:1]),
		.i_wr_data (I_R1R0),
		.i_clear   (buf_clear || (op_done && state_ff == ST_WRITE)),
		.i_rd_idx  (I_FLASH_BUF_IDX),
		.o_rd_data (buf_rd),
		.o_filling (filling)
	);
	assign O_FLASH_BUF_DATA = buf_rd;

	op_timer #(
		.OP_US (OP_US)
	) u_op_timer (
		.i_clk   (I_CLK),
		.i_rst_n (rst_n),
		.i_start (op_start),
		.o_done  (op_done)
	);
endmodule // self_program_flash_control

// file: spm_cfg.svh
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
// Contract
// - Ready irq needs enable, global flag, idle
// - No ready irq during EEPROM write, store
// - Small variant reads rww_busy as zero
// - Bit 5 always reads zero
// - rww_read_enable write clears page buffer
// - Load within three cycles returns lock/fuse
// - Page write stores buffer to addressed page
// - page_write_cmd clears on completion or timeout
// - CPU stalls during NO_READ_WHILE_WRITE_SECTION page write
// - Page erase erases addressed page
// - page_erase_cmd clears on completion or timeout
// - self_program_enable arms store four cycles
// - Plain store fills buffer word at pointer
// - Enable clears after store, timeout; holds busy
// - Only legal low-five-bit patterns take effect
// - Store programs only from boot section
// - Boot split follows boot_size_fuses
// - READ_WHILE_WRITE_SECTION-target operation lets CPU keep running
// - NO_READ_WHILE_WRITE_SECTION-target operation halts CPU
// - rww_busy set until software clears
// - Boot section lies inside NO_READ_WHILE_WRITE_SECTION section
// - Pointer 1 lock, 0 fuse low, 3 high
// - Programmed bits read zero, unprogrammed one
// - EEPROM write blocks programming, fuse reads
// - Operations timed 3.7 ms to 4.5 ms
`define CSR_INDEX      8'h37
`define CSR_BYTE_ADDR  8'hDC
`define BIT_IRQ_EN     7
`define BIT_RWW_BUSY   6
`define BIT_RESERVED   5
`define BIT_RWW_RE     4
`define BIT_LOCK_SEL   3
`define BIT_PG_WRITE   2
`define BIT_PG_ERASE   1
`define BIT_SELF_EN    0
`define CSR_RESET      8'h00
`define PAT_RWW_RE     5'b1_0001
`define PAT_LOCK_SEL   5'b0_1001
`define PAT_PG_WRITE   5'b0_0101
`define PAT_PG_ERASE   5'b0_0011
`define PAT_FILL       5'b0_0001
`define ARM_CYCLES     3'h4
`define LOAD_CYCLES    3'h3
`define CLK_MHZ        200
`define OP_MIN_US      3700
`define OP_MAX_US      4500
`define OP_US          4000
`define PAGE_WORDS     32
`define BOOT_START_0   13'h1C00
`define BOOT_START_1   13'h1E00
`define BOOT_START_2   13'h1F00
`define BOOT_START_3   13'h1F80
`define NO_READ_WHILE_WRITE_SECTION_START     13'h1C00
`define Z_LOCK         16'h0001
`define Z_FUSE_LO      16'h0000
`define Z_FUSE_HI      16'h0003
`define Z_FUSE_EXT     16'h0002
`endif

// file: spm_pkg.sv
package spm_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ERASE = 3'b010,
		ST_WRITE = 3'b100
	} op_state_t;
	typedef struct packed {
		logic       stall;
		logic       read_while_write_section;
		logic [7:0] page;
	} op_desc_t;
endpackage

// file: page_buffer.sv
`include "spm_cfg.svh"
module page_buffer
	import spm_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// Fill port
	input  wire logic        i_wr,
	input  wire logic [4:0]  i_wr_idx,
	input  wire logic [15:0] i_wr_data,
	input  wire logic        i_clear,
	// Drain port
	input  wire logic [4:0]  i_rd_idx,
	output logic      [15:0] o_rd_data,
	output logic             o_filling
);
	logic [15:0]              mem [`PAGE_WORDS];
	logic [`PAGE_WORDS-1:0]   valid_ff;
	// Erased flash reads all ones, so an empty slot does too
	always_ff @(posedge i_clk) begin
		if (i_wr)
			mem[i_wr_idx] <= i_wr_data;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			valid_ff <= '0;
		else if (i_clear)
			valid_ff <= '0;
		else if (i_wr)
			valid_ff[i_wr_idx] <= 1'b1;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_rd_data <= 16'hFFFF;
		else
			o_rd_data <= valid_ff[i_rd_idx] ? mem[i_rd_idx] : 16'hFFFF;
	end
	assign o_filling = |valid_ff;
endmodule // page_buffer

// file: op_timer.sv
`include "spm_cfg.svh"
module op_timer
	import spm_pkg::*;
#(
	parameter int OP_US = `OP_US
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Control
	input  wire logic i_start,
	output logic      o_done
);
	localparam int    TICK_CYC = `CLK_MHZ;
	logic [7:0]       div_ff;
	logic [12:0]      us_ff;
	logic             run_ff;
	logic             tick;
	// Microsecond enable from the core clock, no second clock
	assign tick = (div_ff == 8'(TICK_CYC - 1));
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			div_ff <= '0;
		else if (i_start || tick)
			div_ff <= '0;
		else
			div_ff <= div_ff + 8'h01;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_ff <= 1'b0;
			us_ff  <= '0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				run_ff <= 1'b1;
				us_ff  <= '0;
			end else if (run_ff && tick) begin
				if (us_ff == 13'(OP_US - 1)) begin
					run_ff <= 1'b0;
					o_done <= 1'b1;
				end else
					us_ff <= us_ff + 13'h0001;
			end
		end
	end
endmodule // op_timer

// file: flash_ctl_properties.sv
module flash_ctl_properties
	import spm_pkg::*;
#(
	parameter bit RWW_SUPPORT = 1'b1,
	parameter int OP_US       = 4000
) (
	// Clock and reset
	input wire logic        I_CLK,
	input wire logic        I_RSTN,
	// Bus and core
	input wire logic [31:0] O_AVS_READDATA,
	input wire logic        O_AVS_WAITREQUEST,
	input wire logic        I_SPM,
	input wire logic        I_LPM,
	input wire logic [15:0] I_ZPTR,
	input wire logic [12:0] I_CPU_PC,
	input wire logic        I_GLOBAL_IE,
	input wire logic        I_EE_BUSY,
	input wire logic [1:0]  I_BOOT_SIZE,
	input wire logic [7:0]  I_LOCK_BITS,
	// Results
	input wire logic        O_CPU_STALL,
	input wire logic        O_IRQ,
	input wire logic        O_LPM_VALID,
	input wire logic [7:0]  O_LPM_DATA,
	input wire logic        O_FLASH_ERASE,
	input wire logic        O_FLASH_WRITE,
	input wire logic [7:0]  O_FLASH_PAGE
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OP_CYC = OP_US * 200;
	// Wide enough for a full-length operation at the real clock rate
	logic [31:0] op_cnt_ff;
	logic [12:0] boot_start;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	// Strap sync lag ignored: boot size only changes long before a store
	assign boot_start = (I_BOOT_SIZE == 2'b00) ? 13'h1C00 : (I_BOOT_SIZE == 2'b01) ? 13'h1E00 :
		(I_BOOT_SIZE == 2'b10) ? 13'h1F00 : 13'h1F80;
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			op_cnt_ff <= 32'h0000_0000;
		end else if (O_FLASH_ERASE || O_FLASH_WRITE) begin
			op_cnt_ff <= op_cnt_ff + 32'h0000_0001;
		end else begin
			op_cnt_ff <= 32'h0000_0000;
		end
	end
	sequence s_start;
		$rose(O_FLASH_ERASE) || $rose(O_FLASH_WRITE);
	endsequence
	property p_rsv; !O_AVS_WAITREQUEST |-> O_AVS_READDATA[5] == 1'b0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit read as one");
	property p_irq; O_IRQ |-> $past(I_GLOBAL_IE) && !$past(I_EE_BUSY); endproperty
	a_irq: assert property (p_irq) else $error("irq without enable");
	property p_quiet; (O_FLASH_ERASE || O_FLASH_WRITE) |-> !O_IRQ; endproperty
	a_quiet: assert property (p_quiet) else $error("irq during store");
	property p_start; s_start |-> $past(I_SPM); endproperty
	a_start: assert property (p_start) else $error("operation without store");
	property p_boot; s_start |-> $past(I_CPU_PC) >= boot_start; endproperty
	a_boot: assert property (p_boot) else $error("store from application");
	property p_ee; s_start |-> !$past(I_EE_BUSY); endproperty
	a_ee: assert property (p_ee) else $error("operation during eeprom write");
	property p_no_read_while_write_section; s_start ##0 (O_FLASH_PAGE >= 8'hE0) |-> O_CPU_STALL; endproperty
	a_no_read_while_write_section: assert property (p_no_read_while_write_section) else $error("no stall on no_read_while_write_section page");
	property p_rww; s_start ##0 (RWW_SUPPORT && O_FLASH_PAGE < 8'hE0) |-> !O_CPU_STALL; endproperty
	a_rww: assert property (p_rww) else $error("stall on rww page");
	property p_time; $fell(O_FLASH_ERASE || O_FLASH_WRITE) |-> op_cnt_ff inside {[OP_CYC - 2 : OP_CYC + 2]}; endproperty
	a_time: assert property (p_time) else $error("operation length wrong");
	property p_lock; O_LPM_VALID && $past(I_ZPTR) == 16'h0001 |-> O_LPM_DATA == $past(I_LOCK_BITS); endproperty
	a_lock: assert property (p_lock) else $error("lock read wrong");
	c_write: cover property ($rose(O_FLASH_WRITE));
	c_erase: cover property ($rose(O_FLASH_ERASE) && O_CPU_STALL);
	c_load: cover property (O_LPM_VALID && $past(I_LPM));
endmodule // flash_ctl_properties

bind self_program_flash_control flash_ctl_properties #(.RWW_SUPPORT(RWW_SUPPORT), .OP_US(OP_US)) i_props (
	.I_CLK(I_CLK), .I_RSTN(I_RSTN), .O_AVS_READDATA(O_AVS_READDATA),
	.O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_SPM(I_SPM), .I_LPM(I_LPM), .I_ZPTR(I_ZPTR),
	.I_CPU_PC(I_CPU_PC), .I_GLOBAL_IE(I_GLOBAL_IE), .I_EE_BUSY(I_EE_BUSY),
	.I_BOOT_SIZE(I_BOOT_SIZE), .I_LOCK_BITS(I_LOCK_BITS), .O_CPU_STALL(O_CPU_STALL),
	.O_IRQ(O_IRQ), .O_LPM_VALID(O_LPM_VALID), .O_LPM_DATA(O_LPM_DATA),
	.O_FLASH_ERASE(O_FLASH_ERASE), .O_FLASH_WRITE(O_FLASH_WRITE), .O_FLASH_PAGE(O_FLASH_PAGE)
);

// file: cpu_model.sv
module cpu_model (
	// Clock
	input  wire logic        i_clk,
	// Instruction strobes and operands
	output logic             o_spm,
	output logic             o_lpm,
	output logic      [15:0] o_zptr,
	output logic      [15:0] o_r1r0,
	output logic      [12:0] o_pc
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_spm = 1'b0;
		o_lpm = 1'b0;
		o_zptr = 16'h0000;
		o_r1r0 = 16'h0000;
		o_pc = 13'h1C10;
	end
	task store(input logic [12:0] pc, input logic [15:0] z, input logic [15:0] d);
		@(posedge i_clk);
		o_pc <= pc;
		o_zptr <= z;
		o_r1r0 <= d;
		o_spm <= 1'b1;
		@(posedge i_clk);
		o_spm <= 1'b0;
		// Operand registers are reused at once, so stale data must not matter
		o_r1r0 <= ~d;
	endtask
	task load(input logic [15:0] z);
		@(posedge i_clk);
		o_zptr <= z;
		o_lpm <= 1'b1;
		@(posedge i_clk);
		o_lpm <= 1'b0;
	endtask
endmodule // cpu_model

// file: tb_self_program_flash_control.sv
module tb_self_program_flash_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] STRAPS = 32'hC35A_96F0;
	localparam logic [15:0] ZSEL [4] = '{16'h0001, 16'h0000, 16'h0003, 16'h0002};
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        spm;
	logic        lpm;
	logic        gie = 1'b0;
	logic        ee_busy = 1'b0;
	logic [15:0] zptr;
	logic [15:0] r1r0;
	logic [15:0] buf_data;
	logic [12:0] pc;
	logic        stall;
	logic        irq;
	logic        lpm_valid;
	logic        fl_erase;
	logic        fl_write;
	logic [7:0]  lpm_data;
	logic [7:0]  fl_page;
	logic [1:0]  boot_size = 2'b00;
	logic [4:0]  buf_idx = 5'h00;
	logic [31:0] q;
	int          mismatches = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	always #2.5 clk = ~clk;
	self_program_flash_control #(.RWW_SUPPORT(1'b1), .OP_US(2)) i_dut (
		.I_CLK(clk), .I_RSTN(rst_n), .I_AVS_ADDRESS(avs_address), .I_AVS_READ(avs_read),
		.I_AVS_WRITE(avs_write), .I_AVS_WRITEDATA(avs_writedata), .I_AVS_BYTEENABLE(4'h1),
		.O_AVS_READDATA(avs_readdata), .O_AVS_WAITREQUEST(avs_waitrequest), .I_SPM(spm),
		.I_LPM(lpm), .I_ZPTR(zptr), .I_R1R0(r1r0), .I_CPU_PC(pc), .I_GLOBAL_IE(gie),
		.I_EE_BUSY(ee_busy), .O_CPU_STALL(stall), .O_IRQ(irq), .O_LPM_VALID(lpm_valid),
		.O_LPM_DATA(lpm_data), .I_BOOT_SIZE(boot_size), .I_LOCK_BITS(STRAPS[31:24]),
		.I_FUSE_LO(STRAPS[23:16]), .I_FUSE_HI(STRAPS[15:8]), .I_FUSE_EXT(STRAPS[7:0]),
		.I_FLASH_BUF_IDX(buf_idx), .O_FLASH_BUF_DATA(buf_data), .O_FLASH_ERASE(fl_erase),
		.O_FLASH_WRITE(fl_write), .O_FLASH_PAGE(fl_page)
	);
	cpu_model i_cpu (.i_clk(clk), .o_spm(spm), .o_lpm(lpm), .o_zptr(zptr), .o_r1r0(r1r0), .o_pc(pc));
	task conclude;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= {24'h00_0000, d};
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task wr(input logic [7:0] d);
		bus(1'b1, 8'hDC, d);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(q, {24'h00_0000, exp});
	endtask
	task settle;
		@(posedge clk);
		@(negedge clk);
	endtask
	task wait_idle;
		for (int n = 0; n < 1000 && (fl_erase | fl_write) !== 1'b0; n++) @(negedge clk);
	endtask
	task t_regs;
		rd(8'hDC, 8'h00);
		bus(1'b1, 8'h10, 8'h05);
		rd(8'h10, 8'h00);
		wr(8'hE6);
		rd(8'hDC, 8'h80);
		wr(8'h00);
	endtask
	task t_fill;
		wr(8'h01);
		i_cpu.store(13'h1C10, 16'h000B, 16'hA5C3);
		buf_idx <= 5'h05;
		settle();
		check({16'h0000, buf_data}, 32'h0000_A5C3);
	endtask
	task t_write;
		wr(8'h05);
		i_cpu.store(13'h1C10, 16'h0040, 16'h1234);
		settle();
		check({fl_write, stall, fl_page}, {2'b10, 8'h01});
		rd(8'hDC, 8'h45);
		wait_idle();
		rd(8'hDC, 8'h40);
		wr(8'h11);
		i_cpu.store(13'h1C10, 16'h0000, 16'h0000);
		settle();
		rd(8'hDC, 8'h00);
	endtask
	task t_erase;
		wr(8'h03);
		i_cpu.store(13'h1C10, 16'h3800, 16'h0000);
		settle();
		check({fl_erase, stall, fl_page}, {2'b11, 8'hE0});
		wait_idle();
		check({31'h0, stall}, 32'h0000_0000);
		rd(8'hDC, 8'h00);
	endtask
	task t_timeout;
		wr(8'h05);
		repeat (6) @(posedge clk);
		rd(8'hDC, 8'h00);
		wr(8'h03);
		repeat (6) @(posedge clk);
		i_cpu.store(13'h1C10, 16'h3800, 16'h0000);
		settle();
		check({31'h0, fl_erase}, 32'h0000_0000);
	endtask
	task t_boot;
		@(posedge clk);
		boot_size <= 2'b11;
		repeat (4) @(posedge clk);
		wr(8'h03);
		i_cpu.store(13'h1C10, 16'h3800, 16'h0000);
		settle();
		check({31'h0, fl_erase}, 32'h0000_0000);
		repeat (6) @(posedge clk);
		boot_size <= 2'b00;
		repeat (4) @(posedge clk);
	endtask
	task t_fuse;
		for (int i = 0; i < 4; i++) begin
			wr(8'h09);
			i_cpu.load(ZSEL[i]);
			// Valid stands for one cycle only, so look before the next edge
			@(negedge clk);
			check({23'h0, lpm_valid, lpm_data}, {23'h0, 1'b1, STRAPS[31 - 8 * i -: 8]});
		end
	endtask
	task t_irq;
		wr(8'h80);
		gie <= 1'b1;
		repeat (3) @(negedge clk);
		check({31'h0, irq}, 32'h0000_0001);
		@(posedge clk);
		ee_busy <= 1'b1;
		repeat (3) @(negedge clk);
		check({31'h0, irq}, 32'h0000_0000);
		wr(8'h83);
		rd(8'hDC, 8'h80);
		@(posedge clk);
		ee_busy <= 1'b0;
		gie <= 1'b0;
		wr(8'h00);
	endtask
	task t_clear;
		wr(8'h01);
		i_cpu.store(13'h1C10, 16'h000A, 16'h5A5A);
		wr(8'h11);
		settle();
		settle();
		check({16'h0000, buf_data}, 32'h0000_FFFF);
		repeat (6) @(posedge clk);
	endtask
	// Ceiling covers two flash operations of 400 cycles plus bus traffic
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_fill();
		t_write();
		t_erase();
		t_timeout();
		t_boot();
		t_fuse();
		t_irq();
		t_clear();
		conclude();
	end
endmodule // tb_self_program_flash_control
